// file: hw/airc_ctl.sv
// controller end: AXI4-Lite registers and safe command sequences
// Notes on behaviour
// - end of each sequence sets the flag
// - request only while flag and enable set
// - DMA request always, transfer request unit 0
// - halted after reset, registers blocked until cleared
// - software sets clock bits, clears start, triggers
// - one word dummy read, then module stop
// - standby with start set keeps inputs held
// - standby power cut uses module stop sequence
// - cleared start stops on converter clock tick
// - start reads all results first, skipped while flag set outside continuous
// - single or one-shot: clear flag, then start
// - start from software, two timers, external pin
// - continuous scan repeats from first channel
// - one-cycle scan clears start when done
`timescale 1ns/100ps
module airc_ctl (
	input wire logic CLK, // system clock
	input wire logic SRST, // synchronous reset, high
	airc_if.ctl bus, // register link to the converter
	input wire logic [7:0] AWADDR, // write address
	input wire logic AWVALID, // write address valid
	output logic AWREADY, // write address ready
	input wire logic [31:0] WDATA, // write data
	input wire logic [3:0] WSTRB, // write strobes, ignored
	input wire logic WVALID, // write data valid
	output logic WREADY, // write data ready
	output logic [1:0] BRESP, // write response
	output logic BVALID, // write response valid
	input wire logic BREADY, // write response ready
	input wire logic [7:0] ARADDR, // read address
	input wire logic ARVALID, // read address valid
	output logic ARREADY, // read address ready
	output logic [31:0] RDATA, // read data
	output logic [1:0] RRESP, // read response
	output logic RVALID, // read data valid
	input wire logic RREADY, // read data ready
	output logic IRQ // interrupt, level
);
	typedef struct packed {
		airc_pkg::airc_cst_t st;
		logic [10:0] ctrl;
		logic [2:0] op;
		logic [3:0] step;
		logic [3:0] cnt;
		logic req;
		logic we;
		logic [3:0] addr;
		logic [15:0] wdata;
		logic mstp;
		logic stby;
		logic [15:0] csr_last;
		logic [7:0][9:0] res;
		logic irq_prev;
		logic [2:0] istat;
		logic [2:0] ien;
		logic aw_ok;
		logic w_ok;
		logic [7:0] awaddr;
		logic [31:0] wd;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} airc_cstate_t;

	airc_cstate_t s;
	airc_cstate_t next_s;
	airc_pkg::airc_step_t sp;
	logic [15:0] csr_base;
	logic [15:0] cfg_val;
	logic flag_path;
	logic [7:0] ra;

	always_comb begin
		next_s = s;
		next_s.req = 1'b0;
		csr_base = {1'b1, s.ctrl[airc_pkg::CT_IE], 1'b0,
			s.ctrl[airc_pkg::CT_MODE +: 2], s.ctrl[airc_pkg::CT_CH +: 3],
			8'h00};
		cfg_val = {8'h00, s.ctrl[airc_pkg::CT_CKS +: 2],
			s.ctrl[airc_pkg::CT_TRG +: 3], 3'h0};
		sp = '{kind: airc_pkg::K_END, addr: 4'h0, data: 16'h0000};
		case (s.op)
			airc_pkg::OP_WAKE: case (s.step)
				4'h0: sp.kind = airc_pkg::K_WAKE;
				4'h1: sp = '{airc_pkg::K_WR, airc_pkg::A_CFG, cfg_val};
				4'h2: sp = '{airc_pkg::K_WR, airc_pkg::A_CSR, csr_base};
				default: sp.kind = airc_pkg::K_END;
			endcase
			airc_pkg::OP_START: begin
				if (s.step == 4'h0)
					sp = '{airc_pkg::K_RD, airc_pkg::A_CSR, 16'h0000};
				else if (s.step < step_skip())
					sp = '{airc_pkg::K_RD, s.step - 4'h1, 16'h0000};
				else if (s.step == step_skip())
					sp = '{airc_pkg::K_WR, airc_pkg::A_CSR,
						csr_base & 16'h7fff};
				else if (s.step == step_skip() + 4'h1)
					sp = '{airc_pkg::K_WR, airc_pkg::A_CSR,
						csr_base | 16'h2000};
			end
			airc_pkg::OP_STOP: case (s.step)
				4'h0: sp = '{airc_pkg::K_WR, airc_pkg::A_CSR, csr_base};
				4'h1: sp.kind = airc_pkg::K_WAIT;
				default: sp.kind = airc_pkg::K_END;
			endcase
			airc_pkg::OP_MSTOP, airc_pkg::OP_STBY: case (s.step)
				4'h0: sp = '{airc_pkg::K_WR, airc_pkg::A_CFG,
					airc_pkg::CFG_HALT};
				4'h1: sp = '{airc_pkg::K_WR, airc_pkg::A_CSR, csr_base};
				4'h2: sp.kind = airc_pkg::K_WAIT;
				4'h3: sp = '{airc_pkg::K_RD, 4'h0, 16'h0000};
				4'h4: sp.kind = (s.op == airc_pkg::OP_MSTOP) ?
					airc_pkg::K_MSTP : airc_pkg::K_STBY;
				default: sp.kind = airc_pkg::K_END;
			endcase
			default: sp.kind = airc_pkg::K_END;
		endcase
		flag_path = bus.rdata[airc_pkg::CSR_FLAG] &&
			(bus.rdata[airc_pkg::CSR_MODE +: 2] != airc_pkg::MODE_CONT);
		// command sequencer
		case (s.st)
			airc_pkg::C_IDLE: ;
			airc_pkg::C_ACC: begin
				next_s.step = s.step + 4'h1;
				case (sp.kind)
					airc_pkg::K_WR, airc_pkg::K_RD: begin
						next_s.req = 1'b1;
						next_s.we = (sp.kind == airc_pkg::K_WR);
						next_s.addr = sp.addr;
						next_s.wdata = sp.data;
						next_s.step = s.step;
						next_s.st = airc_pkg::C_ACK;
					end
					airc_pkg::K_WAIT: begin
						next_s.cnt = airc_pkg::STOP_WAIT_CNT;
						next_s.st = airc_pkg::C_WAIT;
					end
					airc_pkg::K_MSTP: next_s.mstp = 1'b1;
					airc_pkg::K_STBY: next_s.stby = 1'b1;
					airc_pkg::K_WAKE: begin
						next_s.mstp = 1'b0;
						next_s.stby = 1'b0;
					end
					default: begin
						next_s.st = airc_pkg::C_IDLE;
						next_s.istat[airc_pkg::IRQ_DONE] = 1'b1;
					end
				endcase
			end
			airc_pkg::C_ACK: begin
				if (bus.ack) begin
					next_s.st = airc_pkg::C_ACC;
					next_s.step = s.step + 4'h1;
					if (!s.we && s.addr == airc_pkg::A_CSR) begin
						next_s.csr_last = bus.rdata;
						if (s.op == airc_pkg::OP_START && flag_path)
							next_s.step = step_skip();
					end else if (!s.we && !s.addr[3]) begin
						next_s.res[s.addr[2:0]] = bus.rdata[9:0];
					end
				end
			end
			airc_pkg::C_WAIT: begin
				next_s.cnt = s.cnt - 4'h1;
				if (s.cnt == 4'h0)
					next_s.st = airc_pkg::C_ACC;
			end
			default: next_s.st = airc_pkg::C_IDLE;
		endcase
		// AXI4-Lite write channel
		if (AWVALID && !s.aw_ok) begin
			next_s.aw_ok = 1'b1;
			next_s.awaddr = AWADDR;
		end
		if (WVALID && !s.w_ok) begin
			next_s.w_ok = 1'b1;
			next_s.wd = WDATA;
		end
		if (s.bvalid && BREADY)
			next_s.bvalid = 1'b0;
		if (s.aw_ok && s.w_ok && !s.bvalid) begin
			next_s.aw_ok = 1'b0;
			next_s.w_ok = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = airc_pkg::RESP_OK;
			case (s.awaddr)
				airc_pkg::R_CTRL: next_s.ctrl = s.wd[10:0];
				airc_pkg::R_CMD: begin
					if (s.st == airc_pkg::C_IDLE && s.wd[2:0] != 3'h0
						&& s.wd[2:0] <= airc_pkg::OP_STBY) begin
						next_s.op = s.wd[2:0];
						next_s.step = 4'h0;
						next_s.st = airc_pkg::C_ACC;
					end else begin
						next_s.istat[airc_pkg::IRQ_REJ] = 1'b1;
					end
				end
				airc_pkg::R_ICLR: next_s.istat = next_s.istat & ~s.wd[2:0];
				airc_pkg::R_IEN: next_s.ien = s.wd[2:0];
				default: next_s.bresp = airc_pkg::RESP_ERR;
			endcase
		end
		// events set after the clear so a same-cycle event survives
		next_s.irq_prev = bus.irq;
		if (bus.irq && !s.irq_prev)
			next_s.istat[airc_pkg::IRQ_CONV] = 1'b1;
		if (s.st == airc_pkg::C_ACC && sp.kind == airc_pkg::K_END)
			next_s.istat[airc_pkg::IRQ_DONE] = 1'b1;
		// AXI4-Lite read channel
		if (s.rvalid && RREADY)
			next_s.rvalid = 1'b0;
		ra = ARADDR;
		if (ARVALID && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = airc_pkg::RESP_OK;
			next_s.rdata = 32'h0000_0000;
			if (ra[7:5] == airc_pkg::R_RES[7:5] && ra[1:0] == 2'h0)
				next_s.rdata = {22'h000000, s.res[ra[4:2]]};
			else case (ra)
				airc_pkg::R_CTRL: next_s.rdata = {21'h000000, s.ctrl};
				airc_pkg::R_STAT: next_s.rdata = {s.csr_last, 13'h0000,
					s.stby, s.mstp, s.st != airc_pkg::C_IDLE};
				airc_pkg::R_ISTAT: next_s.rdata = {29'h00000000, s.istat};
				airc_pkg::R_IEN: next_s.rdata = {29'h00000000, s.ien};
				default: next_s.rresp = airc_pkg::RESP_ERR;
			endcase
		end
	end

	function automatic logic [3:0] step_skip();
		return airc_pkg::STEP_RES_SKIP;
	endfunction

	always_ff @(posedge CLK) begin
		if (SRST) begin
			// converter starts halted
			s <= '{st: airc_pkg::C_IDLE, mstp: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign bus.req = s.req;
	assign bus.we = s.we;
	assign bus.addr = s.addr;
	assign bus.wdata = s.wdata;
	assign bus.mstp = s.mstp;
	assign bus.stby = s.stby;
	assign AWREADY = ~s.aw_ok;
	assign WREADY = ~s.w_ok;
	assign BVALID = s.bvalid;
	assign BRESP = s.bresp;
	assign ARREADY = ~s.rvalid;
	assign RVALID = s.rvalid;
	assign RDATA = s.rdata;
	assign RRESP = s.rresp;
	assign IRQ = |(s.istat & s.ien);
endmodule

// file: hw/airc_dev.sv
// converter control: flag, interrupt, start sources, stop and standby
`timescale 1ns/100ps
module airc_dev #(
	parameter int UNIT = 0 // converter unit number
) (
	input wire logic CLK, // system clock
	input wire logic SRST, // synchronous reset, high
	airc_if.dev bus, // register link
	input wire logic [9:0] AIN, // converted sample of selected input
	output logic [2:0] AIN_SEL, // channel being converted
	input wire logic TIMER_A_TRIG, // pulse timer start pulse
	input wire logic TIMER_B_TRIG, // eight-bit timer start pulse
	input wire logic EXT_TRIG_N, // external start pin, falling edge
	output logic SAMPLE_HOLD, // analog inputs held in standby with start set
	output logic ANALOG_PWR, // analog section powered
	output logic DMA_REQ, // dma controller activation pulse
	output logic XFER_REQ // transfer controller activation pulse
);
	typedef struct packed {
		airc_pkg::airc_dst_t st;
		logic [15:0] csr;
		logic [15:0] cfg;
		logic [7:0][9:0] res;
		logic [2:0] ch;
		logic [2:0] div;
		logic [3:0] conv;
		logic ack;
		logic [15:0] rdata;
		logic [1:0] ext_sync;
		logic ext_prev;
		logic done;
	} airc_dstate_t;

	airc_dstate_t s;
	airc_dstate_t next_s;
	logic tick;
	logic trig;
	logic last;
	logic [2:0] div_max;
	logic [1:0] mode;
	logic [2:0] ch_sel;

	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		next_s.done = 1'b0;
		next_s.ext_sync = {s.ext_sync[0], EXT_TRIG_N};
		next_s.ext_prev = s.ext_sync[1];
		// converter clock as an enable tick from the divider
		case (s.cfg[airc_pkg::CFG_CKS +: 2])
			2'h0: div_max = 3'h7;
			2'h1: div_max = 3'h3;
			2'h2: div_max = 3'h1;
			default: div_max = 3'h0;
		endcase
		tick = (s.div == 3'h0);
		next_s.div = tick ? div_max : s.div - 3'h1;
		// register access; while halted only an empty answer
		if (bus.req) begin
			next_s.ack = 1'b1;
			next_s.rdata = 16'h0000;
			if (!bus.mstp) begin
				if (bus.we) begin
					if (bus.addr == airc_pkg::A_CSR) begin
						next_s.csr = (s.csr & ~airc_pkg::CSR_WMASK)
							| (bus.wdata & airc_pkg::CSR_WMASK);
						if (!bus.wdata[airc_pkg::CSR_FLAG])
							next_s.csr[airc_pkg::CSR_FLAG] = 1'b0;
					end else if (bus.addr == airc_pkg::A_CFG) begin
						next_s.cfg = bus.wdata & airc_pkg::CFG_WMASK;
					end
				end else if (!bus.addr[3]) begin
					next_s.rdata = {6'h00, s.res[bus.addr[2:0]]};
				end else if (bus.addr == airc_pkg::A_CSR) begin
					next_s.rdata = s.csr;
				end else if (bus.addr == airc_pkg::A_CFG) begin
					next_s.rdata = s.cfg;
				end
			end
		end
		// hardware start sources act like a software start
		case (s.cfg[airc_pkg::CFG_TRG +: 3])
			airc_pkg::TRG_TMA: trig = TIMER_A_TRIG;
			airc_pkg::TRG_TMB: trig = TIMER_B_TRIG;
			airc_pkg::TRG_EXT: trig = s.ext_prev & ~s.ext_sync[1];
			default: trig = 1'b0;
		endcase
		if (trig && !bus.mstp)
			next_s.csr[airc_pkg::CSR_ST] = 1'b1;
		mode = next_s.csr[airc_pkg::CSR_MODE +: 2];
		ch_sel = next_s.csr[airc_pkg::CSR_CH +: 3];
		last = (mode == airc_pkg::MODE_SINGLE) || (s.ch == ch_sel);
		// engine is frozen in standby so the held inputs stay put
		if (bus.mstp) begin
			next_s.st = airc_pkg::D_IDLE;
		end else if (!bus.stby) begin
			case (s.st)
				airc_pkg::D_IDLE: begin
					if (next_s.csr[airc_pkg::CSR_ST]) begin
						next_s.st = airc_pkg::D_CONV;
						next_s.conv = 4'h0;
						next_s.ch = (mode == airc_pkg::MODE_SINGLE) ?
							ch_sel : 3'h0;
					end
				end
				airc_pkg::D_CONV: begin
					if (!next_s.csr[airc_pkg::CSR_ST]) begin
						next_s.st = airc_pkg::D_STOP;
					end else if (tick) begin
						next_s.conv = s.conv + 4'h1;
						if (s.conv == airc_pkg::CONV_TICKS) begin
							next_s.conv = 4'h0;
							next_s.res[s.ch] = AIN;
							next_s.ch = s.ch + 3'h1;
							if (last) begin
								// set after any clear, so it wins
								next_s.done = 1'b1;
								next_s.csr[airc_pkg::CSR_FLAG] = 1'b1;
								if (mode == airc_pkg::MODE_CONT) begin
									next_s.ch = 3'h0;
								end else begin
									next_s.csr[airc_pkg::CSR_ST] = 1'b0;
									next_s.st = airc_pkg::D_IDLE;
								end
							end
						end
					end
				end
				airc_pkg::D_STOP: begin
					// a tick comes within eight clocks at the slowest rate
					if (tick)
						next_s.st = airc_pkg::D_IDLE;
				end
				default: next_s.st = airc_pkg::D_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			// pin synchroniser starts at the pin's idle level
			s <= '{st: airc_pkg::D_IDLE, ext_sync: 2'h3, ext_prev: 1'b1,
				default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign bus.ack = s.ack;
	assign bus.rdata = s.rdata;
	assign bus.irq = s.csr[airc_pkg::CSR_FLAG] & s.csr[airc_pkg::CSR_IE];
	assign DMA_REQ = s.done;
	assign XFER_REQ = s.done & (UNIT == 0);
	assign AIN_SEL = s.ch;
	assign SAMPLE_HOLD = bus.stby & s.csr[airc_pkg::CSR_ST];
	assign ANALOG_PWR = ~bus.mstp & ~(bus.stby & ~s.csr[airc_pkg::CSR_ST]);
endmodule

// file: hw/airc_if.sv
// register link between the controller and the converter control
`timescale 1ns/100ps
interface airc_if;
	logic req;
	logic we;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic ack;
	logic irq;
	logic mstp;
	logic stby;
	modport dev(input req, we, addr, wdata, mstp, stby,
		output ack, rdata, irq);
	modport ctl(output req, we, addr, wdata, mstp, stby,
		input ack, rdata, irq);
endinterface

// file: hw/airc_pkg.sv
// shared constants and types for converter control and its controller
package airc_pkg;
	localparam int CLK_MHZ = 20;
	localparam int STOP_WAIT_NS = 500;
	localparam int STOP_WAIT_CYC = (STOP_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] STOP_WAIT_CNT = 4'(STOP_WAIT_CYC - 1);
	localparam logic [3:0] CONV_TICKS = 4'hf;
	// device register index on the link
	localparam logic [3:0] A_CSR = 4'h8;
	localparam logic [3:0] A_CFG = 4'h9;
	// conv_ctrl_status_reg fields
	localparam int CSR_FLAG = 15;
	localparam int CSR_IE = 14;
	localparam int CSR_ST = 13;
	localparam int CSR_MODE = 11;
	localparam int CSR_CH = 8;
	localparam logic [15:0] CSR_WMASK = 16'h7f00;
	localparam logic [15:0] CSR_RST = 16'h0000;
	// conv_config_reg fields
	localparam int CFG_CKS = 6;
	localparam int CFG_TRG = 3;
	localparam logic [15:0] CFG_WMASK = 16'h00f8;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] CFG_HALT = 16'h00c0;
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_ONE = 2'h1;
	localparam logic [1:0] MODE_CONT = 2'h2;
	localparam logic [2:0] TRG_TMA = 3'h4;
	localparam logic [2:0] TRG_TMB = 3'h2;
	localparam logic [2:0] TRG_EXT = 3'h6;
	// controller register byte offsets
	localparam logic [7:0] R_CTRL = 8'h00;
	localparam logic [7:0] R_CMD = 8'h04;
	localparam logic [7:0] R_STAT = 8'h08;
	localparam logic [7:0] R_ISTAT = 8'h0c;
	localparam logic [7:0] R_ICLR = 8'h10;
	localparam logic [7:0] R_IEN = 8'h14;
	localparam logic [7:0] R_RES = 8'h20;
	localparam int CT_MODE = 0;
	localparam int CT_TRG = 2;
	localparam int CT_CKS = 5;
	localparam int CT_IE = 7;
	localparam int CT_CH = 8;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_CONV = 1;
	localparam int IRQ_REJ = 2;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam logic [2:0] OP_WAKE = 3'h1;
	localparam logic [2:0] OP_START = 3'h2;
	localparam logic [2:0] OP_STOP = 3'h3;
	localparam logic [2:0] OP_MSTOP = 3'h4;
	localparam logic [2:0] OP_STBY = 3'h5;
	localparam logic [3:0] STEP_RES_SKIP = 4'h9;
	typedef enum logic [2:0] {
		D_IDLE = 3'b001,
		D_CONV = 3'b010,
		D_STOP = 3'b100
	} airc_dst_t;
	typedef enum logic [3:0] {
		C_IDLE = 4'b0001,
		C_ACC = 4'b0010,
		C_ACK = 4'b0100,
		C_WAIT = 4'b1000
	} airc_cst_t;
	typedef enum logic [2:0] {
		K_WR, K_RD, K_WAIT, K_MSTP, K_STBY, K_WAKE, K_END
	} airc_kind_t;
	typedef struct packed {
		airc_kind_t kind;
		logic [3:0] addr;
		logic [15:0] data;
	} airc_step_t;
endpackage

// file: sim/airc_sva.sv
// assertions on the converter link and the converter outputs
`timescale 1ns/100ps
module airc_sva #(
	parameter int UNIT = 0 // converter unit number
) (
	input wire logic CLK, // system clock
	input wire logic SRST, // synchronous reset, high
	input wire logic req, // access request
	input wire logic we, // write
	input wire logic [3:0] addr, // register index
	input wire logic [15:0] wdata, // write data
	input wire logic [15:0] rdata, // read data
	input wire logic ack, // access answer
	input wire logic irq, // conversion end request
	input wire logic mstp, // module stop
	input wire logic stby, // software standby
	input wire logic SAMPLE_HOLD, // inputs held
	input wire logic ANALOG_PWR, // analog power
	input wire logic DMA_REQ, // dma activation
	input wire logic XFER_REQ // transfer activation
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	sequence s_ie_off;
		req && we && !mstp && addr == airc_pkg::A_CSR
			&& !wdata[airc_pkg::CSR_IE];
	endsequence
	sequence s_flag_off;
		req && we && !mstp && addr == airc_pkg::A_CSR
			&& !wdata[airc_pkg::CSR_FLAG];
	endsequence
	// an end of sequence in this window would legally set the flag again
	sequence s_no_end;
		!DMA_REQ [*2];
	endsequence
	property p_ack;
		req |=> ack ##1 !ack;
	endproperty
	property p_ack_cause;
		ack |-> $past(req);
	endproperty
	property p_halt_rd;
		req && !we && mstp |=> rdata == 16'h0000;
	endproperty
	property p_pwr;
		mstp |-> !ANALOG_PWR;
	endproperty
	property p_hold;
		SAMPLE_HOLD |-> stby;
	endproperty
	property p_xfer;
		XFER_REQ == (DMA_REQ && UNIT == 0);
	endproperty
	property p_dma;
		DMA_REQ |=> !DMA_REQ;
	endproperty
	property p_ie_clr;
		s_ie_off |=> !irq;
	endproperty
	property p_flag_clr;
		s_flag_off ##1 s_no_end |-> !irq;
	endproperty
	a_ack: assert property (p_ack)
		else $error("link access not answered in one cycle");
	a_ack_cause: assert property (p_ack_cause)
		else $error("link answer without request");
	a_halt_rd: assert property (p_halt_rd)
		else $error("halted converter returned data");
	a_pwr: assert property (p_pwr)
		else $error("analog power on while halted");
	a_hold: assert property (p_hold)
		else $error("inputs held outside standby");
	a_xfer: assert property (p_xfer)
		else $error("transfer request does not follow dma request");
	a_dma: assert property (p_dma)
		else $error("dma request longer than one cycle");
	a_ie_clr: assert property (p_ie_clr)
		else $error("request stays after enable cleared");
	a_flag_clr: assert property (p_flag_clr)
		else $error("request stays after flag cleared");
endmodule

// file: sim/airc_test.sv
// self-checking bench: controller and converter control on one link
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
	$display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module airc_test;
	logic CLK, SRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY, IRQ, SAMPLE_HOLD, ANALOG_PWR;
	logic TIMER_A_TRIG, TIMER_B_TRIG, EXT_TRIG_N, DMA_REQ, XFER_REQ;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rd;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, rr;
	logic [9:0] AIN, ain;
	logic [2:0] AIN_SEL, ch;
	logic [2:0] trg_tab [3];
	int bad_count, checks, dma_count, xfer_count, base;
	airc_if link();
	airc_dev #(.UNIT(0)) i_airc_dev (.CLK(CLK), .SRST(SRST), .bus(link),
		.AIN(AIN), .AIN_SEL(AIN_SEL), .TIMER_A_TRIG(TIMER_A_TRIG),
		.TIMER_B_TRIG(TIMER_B_TRIG), .EXT_TRIG_N(EXT_TRIG_N),
		.SAMPLE_HOLD(SAMPLE_HOLD), .ANALOG_PWR(ANALOG_PWR),
		.DMA_REQ(DMA_REQ), .XFER_REQ(XFER_REQ));
	airc_ctl i_airc_ctl (.CLK(CLK), .SRST(SRST), .bus(link), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .IRQ(IRQ));
	airc_sva #(.UNIT(0)) i_airc_sva (.CLK(CLK), .SRST(SRST), .req(link.req),
		.we(link.we), .addr(link.addr), .wdata(link.wdata),
		.rdata(link.rdata), .ack(link.ack), .irq(link.irq), .mstp(link.mstp),
		.stby(link.stby), .SAMPLE_HOLD(SAMPLE_HOLD), .ANALOG_PWR(ANALOG_PWR),
		.DMA_REQ(DMA_REQ), .XFER_REQ(XFER_REQ));
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		if (DMA_REQ === 1'b1) dma_count <= dma_count + 1;
		if (XFER_REQ === 1'b1) xfer_count <= xfer_count + 1;
	end
	function automatic logic [31:0] ctrl_w(logic [1:0] m, logic [2:0] t,
		logic [1:0] k, logic ie, logic [2:0] c);
		return {21'h0, c, ie, k, t, m};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic fail_out();
		bad_count++;
		$display("Error t=%0t wait limit got %h exp %h", $time, 1'b0, 1'b1);
		summarize();
	endtask
	// both write channels offered together, each released when taken
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic aw_p, w_p, aw_hit, w_hit, b_hit;
		aw_p = 1'b1;
		w_p = 1'b1;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		for (int n = 0; aw_p || w_p; n++) begin
			@(negedge CLK);
			aw_hit = aw_p && AWREADY;
			w_hit = w_p && WREADY;
			@(posedge CLK);
			if (aw_hit) AWVALID <= 1'b0;
			if (w_hit) WVALID <= 1'b0;
			aw_p = aw_p && !aw_hit;
			w_p = w_p && !w_hit;
			if (n > 200) fail_out();
		end
		BREADY <= 1'b1;
		for (int n = 0; n < 200; n++) begin
			@(negedge CLK);
			b_hit = BVALID;
			rr = BRESP;
			@(posedge CLK);
			if (b_hit) break;
		end
		if (!b_hit) fail_out();
		BREADY <= 1'b0;
	endtask
	// rready stays high between reads, so back-to-back calls never
	// lower and raise it in one time step
	task automatic rd_(logic [7:0] a);
		logic hit, ar_hit;
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (int n = 0; n < 400; n++) begin
			@(negedge CLK);
			hit = RVALID;
			ar_hit = ARREADY;
			rd = RDATA;
			rr = RRESP;
			@(posedge CLK);
			if (ar_hit) ARVALID <= 1'b0;
			if (hit) break;
		end
		if (!hit) fail_out();
	endtask
	task automatic poll(logic [7:0] a, int b, logic v);
		for (int n = 0; n < 300; n++) begin
			rd_(a);
			if (rd[b] === v) return;
		end
		fail_out();
	endtask
	task automatic cmd(logic [2:0] op);
		wr(airc_pkg::R_CMD, {29'h0, op});
		poll(airc_pkg::R_STAT, 0, 1'b0);
	endtask
	task automatic pulse(int i);
		if (i == 0) TIMER_A_TRIG <= 1'b1;
		if (i == 1) TIMER_B_TRIG <= 1'b1;
		if (i == 2) EXT_TRIG_N <= 1'b0;
		// timer starts are one-cycle pulses; the pin is held longer
		@(posedge CLK);
		TIMER_A_TRIG <= 1'b0;
		TIMER_B_TRIG <= 1'b0;
		repeat (2) @(posedge CLK);
		EXT_TRIG_N <= 1'b1;
	endtask
	initial begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		{TIMER_A_TRIG, TIMER_B_TRIG, EXT_TRIG_N, SRST} = 4'h3;
		{AWADDR, ARADDR, WDATA, WSTRB, AIN} = '0;
		{bad_count, checks, dma_count, xfer_count} = '0;
		trg_tab = '{airc_pkg::TRG_TMA, airc_pkg::TRG_TMB, airc_pkg::TRG_EXT};
		void'($urandom(16));
		ch = 3'($urandom % 8);
		ain = 10'($urandom % 1024);
		repeat (6) @(posedge CLK);
		SRST <= 1'b0;
		AIN <= ain;
		rd_(airc_pkg::R_STAT);
		`CHK(rd[2:0], 3'h2)
		rd_(8'h18);
		`CHK({rr, rd}, {2'h2, 32'h0})
		wr(airc_pkg::R_STAT, 32'h1);
		`CHK(rr, airc_pkg::RESP_ERR)
		wr(airc_pkg::R_IEN, 32'h7);
		$display("test reset and map done");
		wr(airc_pkg::R_CTRL, ctrl_w(airc_pkg::MODE_SINGLE, 3'h0, 2'h3, 1'b1, ch));
		cmd(airc_pkg::OP_WAKE);
		base = dma_count;
		cmd(airc_pkg::OP_START);
		poll(airc_pkg::R_ISTAT, airc_pkg::IRQ_CONV, 1'b1);
		`CHK(dma_count - base, 1)
		`CHK(xfer_count, dma_count)
		wr(airc_pkg::R_IEN, 32'h0);
		@(negedge CLK);
		`CHK(IRQ, 1'b0)
		@(posedge CLK);
		wr(airc_pkg::R_IEN, 32'h2);
		@(negedge CLK);
		`CHK(IRQ, 1'b1)
		@(posedge CLK);
		wr(airc_pkg::R_ICLR, 32'h7);
		@(negedge CLK);
		`CHK(IRQ, 1'b0)
		@(posedge CLK);
		cmd(airc_pkg::OP_START);
		poll(airc_pkg::R_ISTAT, airc_pkg::IRQ_CONV, 1'b1);
		`CHK(dma_count - base, 2)
		$display("test single and restart done");
		for (int i = 0; i < 3; i++) begin
			wr(airc_pkg::R_ICLR, 32'h7);
			wr(airc_pkg::R_CTRL, ctrl_w(airc_pkg::MODE_SINGLE, trg_tab[i], 2'h3,
				1'b1, ch));
			cmd(airc_pkg::OP_WAKE);
			base = dma_count;
			pulse(i);
			// flag is still set, so irq makes no new edge: watch dma
			for (int n = 0; n < 400 && dma_count == base; n++)
				@(posedge CLK);
			`CHK(dma_count - base, 1)
		end
		$display("test trigger sources done");
		wr(airc_pkg::R_CTRL, ctrl_w(airc_pkg::MODE_CONT, 3'h0, 2'h3, 1'b1, 3'h1));
		cmd(airc_pkg::OP_WAKE);
		cmd(airc_pkg::OP_START);
		rd_(8'(airc_pkg::R_RES + {3'h0, ch, 2'h0}));
		`CHK(rd[9:0], ain)
		base = dma_count;
		for (int n = 0; n < 400 && dma_count < base + 2; n++) @(posedge CLK);
		`CHK(dma_count >= base + 2, 1'b1)
		cmd(airc_pkg::OP_STOP);
		base = dma_count;
		repeat (80) @(posedge CLK);
		`CHK(dma_count, base)
		$display("test continuous scan and stop done");
		wr(airc_pkg::R_CTRL, ctrl_w(airc_pkg::MODE_ONE, 3'h0, 2'h3, 1'b1, 3'h2));
		cmd(airc_pkg::OP_WAKE);
		wr(airc_pkg::R_ICLR, 32'h7);
		base = dma_count;
		wr(airc_pkg::R_CMD, {29'h0, airc_pkg::OP_START});
		wr(airc_pkg::R_CMD, {29'h0, airc_pkg::OP_STOP});
		poll(airc_pkg::R_ISTAT, airc_pkg::IRQ_REJ, 1'b1);
		poll(airc_pkg::R_ISTAT, airc_pkg::IRQ_CONV, 1'b1);
		repeat (120) @(posedge CLK);
		`CHK(dma_count - base, 1)
		$display("test one-cycle scan done");
		wr(airc_pkg::R_CTRL, ctrl_w(airc_pkg::MODE_SINGLE, 3'h0, 2'h1, 1'b0, ch));
		cmd(airc_pkg::OP_WAKE);
		cmd(airc_pkg::OP_STBY);
		rd_(airc_pkg::R_STAT);
		`CHK(rd[2:1], 2'h2)
		@(negedge CLK);
		`CHK({ANALOG_PWR, SAMPLE_HOLD}, 2'h0)
		@(posedge CLK);
		cmd(airc_pkg::OP_WAKE);
		cmd(airc_pkg::OP_MSTOP);
		rd_(airc_pkg::R_STAT);
		`CHK(rd[2:1], 2'h1)
		`CHK(ANALOG_PWR, 1'b0)
		// a halted converter answers reads with zero
		cmd(airc_pkg::OP_START);
		rd_(8'(airc_pkg::R_RES + {3'h0, ch, 2'h0}));
		`CHK(rd[9:0], 10'h000)
		$display("test standby and module stop done");
		summarize();
	end
endmodule
